// >>> pkg/fp_state_consts.vh
`ifndef FP_STATE_CONSTS_VH
`define FP_STATE_CONSTS_VH
// flags register layout
`define FLG_WIDTH 64
`define FLG_CARRY 0
`define FLG_ONE 1
`define FLG_PARITY 2
`define FLG_ZERO3 3
`define FLG_AUX 4
`define FLG_ZERO5 5
`define FLG_ZERO_RES 6
`define FLG_SIGN 7
`define FLG_STEP 8
`define FLG_INTR 9
`define FLG_DIR 10
`define FLG_OVF 11
`define FLG_PRIV_LO 12
`define FLG_PRIV_HI 13
`define FLG_NEST 14
`define FLG_ZERO15 15
`define FLG_RESUME 16
`define FLG_V86 17
`define FLG_ALIGN 18
`define FLG_VINT 19
`define FLG_VPEND 20
`define FLG_IDENT 21
`define FLG_RSV_LO 22
`define FLG_RSV_HI 63
// writable defined-field mask, fixed-one mask, reset value
`define FLG_WMASK 64'h0000_0000_003F_7FD5
`define FLG_ONES 64'h0000_0000_0000_0002
`define FLG_RESET 64'h0000_0000_0000_0002
// application register slots
`define AR_FP_CONTROL 7'h15
`define AR_FLAGS 7'h18
`define AR_FP_STATUS_TAG 7'h1C
`define AR_FP_INSTR_PTR 7'h1D
`define AR_FP_DATA_PTR 7'h1E
`define FP_DATA_PTR_WIDTH 48
// stack top field position in the fp control register
`define STACK_TOP_LO 11
`define STACK_TOP_HI 13
// physical stack window
`define FP_STACK_PHYS_BASE 7'h08
`define FP_STACK_PHYS_LAST 7'h0F
`define FP_EXT_WIDTH 80
// extended-format exponent values
`define EXP_BIAS_EXT 15'h3FFF
`define EXP_SGL_DENORM 15'h3F81
`define EXP_DBL_DENORM 15'h3C01
`endif

// >>> rtl/fp_stack_mem.v
`include "fp_state_consts.vh"
module fp_stack_mem (
    // clock
    input wire clk_i,
    // write port
    input wire wr_en_i,
    input wire [2:0] wr_idx_i,
    input wire [`FP_EXT_WIDTH-1:0] wr_data_i,
    // read port
    input wire [2:0] rd_idx_i,
    output reg [`FP_EXT_WIDTH-1:0] rd_data_o
);
    reg [`FP_EXT_WIDTH-1:0] mem [0:7];

    always @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem[wr_idx_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_idx_i];
    end
endmodule

// >>> rtl/legacy_flags_fp_state_map.v
`include "fp_state_consts.vh"
module legacy_flags_fp_state_map (
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // application register access
    input wire ar_wr_i,
    input wire ar_rd_i,
    input wire ar_legacy_i,
    input wire [6:0] ar_idx_i,
    input wire [63:0] ar_wdata_i,
    output reg [63:0] ar_rdata_o,
    output reg ar_rvalid_o,
    output reg rsv_field_fault_o,
    // legacy instruction flags update
    input wire flags_upd_i,
    input wire [63:0] flags_upd_val_i,
    output reg [63:0] legacy_flags_o,
    // floating-point register access
    input wire fp_wr_i,
    input wire fp_rd_i,
    input wire fp_legacy_i,
    input wire [6:0] fp_reg_i,
    input wire [`FP_EXT_WIDTH-1:0] fp_wdata_i,
    input wire fp_load_sgl_i,
    input wire fp_load_dbl_i,
    output reg [`FP_EXT_WIDTH-1:0] fp_rdata_o,
    output reg fp_rvalid_o,
    output reg fp_invalid_fault_o
);
    reg rst_s1_ff;
    reg rst_s2_ff;
    wire rst_b = rst_s2_ff;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    reg [63:0] flags_ff;
    reg [63:0] fp_control_ff;
    reg [63:0] fp_status_tag_ff;
    reg [63:0] fp_instr_ptr_ff;
    reg [`FP_DATA_PTR_WIDTH-1:0] fp_data_ptr_ff;
    reg [63:0] nxt_flags;

    // fixed bits forced on every store so no path can disturb them
    function [63:0] clean_flags;
        input [63:0] v;
        begin
            clean_flags = (v & `FLG_WMASK) | `FLG_ONES;
        end
    endfunction

    // stack index for a register number; legacy adds the top pointer
    function [2:0] stack_slot;
        input [6:0] reg_num;
        input legacy;
        input [2:0] top;
        begin
            if (legacy)
                stack_slot = reg_num[2:0] + top;
            else
                stack_slot = reg_num[2:0];
        end
    endfunction

    wire [2:0] stack_top = fp_control_ff[`STACK_TOP_HI:`STACK_TOP_LO];
    wire fp_in_stack = (fp_reg_i >= `FP_STACK_PHYS_BASE) && (fp_reg_i <= `FP_STACK_PHYS_LAST);
    wire rsv_nonzero = |ar_wdata_i[`FLG_RSV_HI:`FLG_RSV_LO];
    wire flags_sel = (ar_idx_i == `AR_FLAGS);
    // reserved bits only fault native writes; legacy writes are masked
    wire flags_fault = ar_wr_i && flags_sel && !ar_legacy_i && rsv_nonzero;

    always @*
    begin
        nxt_flags = flags_ff;
        if (flags_upd_i)
            nxt_flags = clean_flags(flags_upd_val_i);
        if (ar_wr_i && flags_sel && !flags_fault)
            nxt_flags = clean_flags(ar_wdata_i);
    end

    always @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flags_ff <= `FLG_RESET;
            fp_control_ff <= 64'h0000_0000_0000_0000;
            fp_status_tag_ff <= 64'h0000_0000_0000_0000;
            fp_instr_ptr_ff <= 64'h0000_0000_0000_0000;
            fp_data_ptr_ff <= 48'h0000_0000_0000;
            ar_rdata_o <= 64'h0000_0000_0000_0000;
            ar_rvalid_o <= 1'b0;
            rsv_field_fault_o <= 1'b0;
            legacy_flags_o <= `FLG_RESET;
        end
        else
        begin
            flags_ff <= nxt_flags;
            legacy_flags_o <= nxt_flags;
            rsv_field_fault_o <= flags_fault;
            if (ar_wr_i)
            begin
                case (ar_idx_i)
                    `AR_FP_CONTROL: fp_control_ff <= ar_wdata_i;
                    `AR_FP_STATUS_TAG: fp_status_tag_ff <= ar_wdata_i;
                    `AR_FP_INSTR_PTR: fp_instr_ptr_ff <= ar_wdata_i;
                    `AR_FP_DATA_PTR: fp_data_ptr_ff <= ar_wdata_i[`FP_DATA_PTR_WIDTH-1:0];
                    default: ;
                endcase
            end
            ar_rvalid_o <= ar_rd_i;
            if (ar_rd_i)
            begin
                case (ar_idx_i)
                    `AR_FLAGS: ar_rdata_o <= flags_ff;
                    `AR_FP_CONTROL: ar_rdata_o <= fp_control_ff;
                    `AR_FP_STATUS_TAG: ar_rdata_o <= fp_status_tag_ff;
                    `AR_FP_INSTR_PTR: ar_rdata_o <= fp_instr_ptr_ff;
                    `AR_FP_DATA_PTR: ar_rdata_o <= {16'h0000, fp_data_ptr_ff};
                    default: ar_rdata_o <= 64'h0000_0000_0000_0000;
                endcase
            end
        end
    end

    // flags never feed the fp path: native execution ignores them
    wire [`FP_EXT_WIDTH-1:0] in_val = fp_wdata_i;
    wire [14:0] in_exp = in_val[78:64];
    wire [63:0] in_sig = in_val[63:0];
    wire is_denorm_load = (fp_load_sgl_i || fp_load_dbl_i) && (in_exp == 15'h0000)
        && (in_sig != 64'h0000_0000_0000_0000);

    // leading zero count for normalisation
    reg [6:0] lz;
    integer i;
    always @*
    begin
        lz = 7'h00;
        for (i = 0; i < 64; i = i + 1)
            if (in_sig[i])
                lz = 7'd63 - i[6:0];
    end

    wire [14:0] base_exp = fp_load_sgl_i ? `EXP_SGL_DENORM : `EXP_DBL_DENORM;
    wire [63:0] norm_sig = in_sig << lz;
    wire [14:0] norm_exp = base_exp - {8'h00, lz};

    reg [`FP_EXT_WIDTH-1:0] store_val;
    always @*
    begin
        store_val = in_val;
        if (is_denorm_load)
        begin
            if (fp_legacy_i)
                store_val = {in_val[79], norm_exp, norm_sig};
            else
                store_val = {in_val[79], base_exp, in_sig};
        end
    end

    wire [2:0] slot = stack_slot(fp_reg_i, fp_legacy_i, stack_top);
    wire [`FP_EXT_WIDTH-1:0] mem_rdata;

    // only regs 8-15 are held here; other numbers live in the core's main register file
    fp_stack_mem u_stack (
        .clk_i(clk_i),
        .wr_en_i(fp_wr_i && fp_in_stack),
        .wr_idx_i(slot),
        .wr_data_i(store_val),
        .rd_idx_i(slot),
        .rd_data_o(mem_rdata)
    );

    reg rd_pend_ff;
    reg rd_legacy_ff;
    always @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_pend_ff <= 1'b0;
            rd_legacy_ff <= 1'b0;
        end
        else
        begin
            rd_pend_ff <= fp_rd_i && fp_in_stack;
            rd_legacy_ff <= fp_legacy_i;
        end
    end

    // marked denormal exponents are illegal to legacy consumers
    wire mem_marked = (mem_rdata[78:64] == `EXP_SGL_DENORM || mem_rdata[78:64] == `EXP_DBL_DENORM)
        && !mem_rdata[63];

    always @(posedge clk_i or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fp_rdata_o <= 80'h0000_0000_0000_0000_0000;
            fp_rvalid_o <= 1'b0;
            fp_invalid_fault_o <= 1'b0;
        end
        else
        begin
            fp_rvalid_o <= rd_pend_ff;
            if (rd_pend_ff)
                fp_rdata_o <= mem_rdata;
            fp_invalid_fault_o <= rd_pend_ff && rd_legacy_ff && mem_marked;
        end
    end
endmodule

// >>> bench/legacy_flags_fp_state_map_checker.sv
`include "fp_state_consts.vh"
module legacy_flags_fp_state_map_checker (
    // inputs
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic ar_wr_i,
    input wire logic ar_rd_i,
    input wire logic ar_legacy_i,
    input wire logic [6:0] ar_idx_i,
    input wire logic [63:0] ar_wdata_i,
    input wire logic flags_upd_i,
    input wire logic fp_rd_i,
    input wire logic [6:0] fp_reg_i,
    // outputs
    input wire logic ar_rvalid_o,
    input wire logic rsv_field_fault_o,
    input wire logic [63:0] legacy_flags_o,
    input wire logic fp_rvalid_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence bad_wr;
        ar_wr_i && !ar_legacy_i && ar_idx_i == `AR_FLAGS && ar_wdata_i[63:22] != 0;
    endsequence
    sequence good_wr;
        ar_wr_i && ar_idx_i == `AR_FLAGS && (ar_legacy_i || ar_wdata_i[63:22] == 0);
    endsequence
    fixed_one_a: assert property (legacy_flags_o[1])
        else $error("bit 1 low");
    fixed_zero_a: assert property (!legacy_flags_o[3] && !legacy_flags_o[5]
        && !legacy_flags_o[15]) else $error("fixed zero bit set");
    rsv_clear_a: assert property (legacy_flags_o[63:22] == 0)
        else $error("reserved set");
    fault_raise_a: assert property (bad_wr |=> rsv_field_fault_o)
        else $error("no fault");
    // a legacy result update in the same cycle may still land, so it is left out here
    fault_hold_a: assert property (bad_wr ##0 !flags_upd_i
        |=> $stable(legacy_flags_o)) else $error("faulting write landed");
    fault_cause_a: assert property (rsv_field_fault_o
        |-> $past(ar_wr_i && !ar_legacy_i && ar_idx_i == `AR_FLAGS && ar_wdata_i[63:22] != 0))
        else $error("spurious fault");
    clean_write_a: assert property (good_wr |=> !rsv_field_fault_o
        && legacy_flags_o == (($past(ar_wdata_i) & `FLG_WMASK) | `FLG_ONES))
        else $error("bad flags");
    ar_read_a: assert property (ar_rd_i |=> ar_rvalid_o)
        else $error("no ar read answer");
    fp_read_a: assert property (fp_rd_i && fp_reg_i[6:3] == 1 |-> ##2 fp_rvalid_o)
        else $error("no fp read answer");
endmodule
bind legacy_flags_fp_state_map legacy_flags_fp_state_map_checker
    legacy_flags_fp_state_map_checker_i (
    .clk_i, .rst_b_i, .ar_wr_i, .ar_rd_i, .ar_legacy_i, .ar_idx_i, .ar_wdata_i, .flags_upd_i,
    .fp_rd_i, .fp_reg_i, .ar_rvalid_o, .rsv_field_fault_o, .legacy_flags_o, .fp_rvalid_o);

// >>> bench/legacy_flags_fp_state_map_tb.sv
`include "fp_state_consts.vh"
module legacy_flags_fp_state_map_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic lg; logic [6:0] idx; logic [63:0] wd; logic [63:0] rd; logic f;} row_t;
    logic clk_i = 0, rst_b_i = 0, ar_wr_i = 0, ar_rd_i = 0, ar_legacy_i = 0, flags_upd_i = 0;
    logic fp_wr_i = 0, fp_rd_i = 0, fp_legacy_i = 0, fp_load_sgl_i = 0, fp_load_dbl_i = 0;
    logic ar_rvalid_o, rsv_field_fault_o, fp_rvalid_o, fp_invalid_fault_o;
    logic [6:0] ar_idx_i = 0, fp_reg_i = 0;
    logic [63:0] ar_wdata_i = 0, flags_upd_val_i = 0, ar_rdata_o, legacy_flags_o;
    logic [79:0] fp_wdata_i = 0, fp_rdata_o;
    int err_count = 0, total_checks = 0;
    row_t rows [9];
    legacy_flags_fp_state_map legacy_flags_fp_state_map_i (.clk_i, .rst_b_i, .ar_wr_i, .ar_rd_i,
        .ar_legacy_i, .ar_idx_i, .ar_wdata_i, .ar_rdata_o, .ar_rvalid_o, .rsv_field_fault_o,
        .flags_upd_i, .flags_upd_val_i, .legacy_flags_o, .fp_wr_i, .fp_rd_i, .fp_legacy_i,
        .fp_reg_i, .fp_wdata_i, .fp_load_sgl_i, .fp_load_dbl_i, .fp_rdata_o, .fp_rvalid_o,
        .fp_invalid_fault_o);
    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // reads wait a bounded number of cycles for the answer
    task automatic ar_op(input logic wr, input logic lg, input logic [6:0] idx,
        input logic [63:0] d);
        int n;
        @(posedge clk_i);
        ar_wr_i <= wr;
        ar_rd_i <= !wr;
        ar_legacy_i <= lg;
        ar_idx_i <= idx;
        ar_wdata_i <= d;
        @(posedge clk_i);
        ar_wr_i <= 0;
        ar_rd_i <= 0;
        #1;
        for (n = 0; !wr && ar_rvalid_o !== 1 && n < 4; n++)
            @(posedge clk_i) #1;
    endtask
    task automatic fp_op(input logic wr, input logic lg, input logic [6:0] r,
        input logic [1:0] ld, input logic [79:0] d);
        int n;
        @(posedge clk_i);
        fp_wr_i <= wr;
        fp_rd_i <= !wr;
        fp_legacy_i <= lg;
        fp_reg_i <= r;
        fp_wdata_i <= d;
        {fp_load_dbl_i, fp_load_sgl_i} <= ld;
        @(posedge clk_i);
        fp_wr_i <= 0;
        fp_rd_i <= 0;
        #1;
        for (n = 0; !wr && fp_rvalid_o !== 1 && n < 4; n++)
            @(posedge clk_i) #1;
    endtask
    // flags update from a legacy result, optionally racing a native clean write
    task automatic upd(input logic w);
        @(posedge clk_i);
        flags_upd_i <= 1;
        flags_upd_val_i <= '1;
        ar_wr_i <= w;
        ar_legacy_i <= 0;
        ar_idx_i <= `AR_FLAGS;
        ar_wdata_i <= 0;
        @(posedge clk_i);
        flags_upd_i <= 0;
        ar_wr_i <= 0;
        #1;
    endtask
    initial
    begin
        #20000;
        err_count++;
        summarize();
    end
    initial
    begin
        rows = '{'{0, `AR_FLAGS, 64'h0, 64'h2, 0},
            '{0, `AR_FLAGS, 64'h8000_0000_0000_0000, 64'h2, 1},
            '{1, `AR_FLAGS, '1, 64'h3F_7FD7, 0}, '{0, `AR_FLAGS, 64'h802A, 64'h2, 0},
            '{0, `AR_FP_STATUS_TAG, 64'hA5A5, 64'hA5A5, 0},
            '{0, `AR_FP_INSTR_PTR, 64'h1234, 64'h1234, 0},
            '{0, `AR_FP_DATA_PTR, '1, 64'hFFFF_FFFF_FFFF, 0}, '{0, 7'h00, 64'h1, 64'h0, 0},
            '{0, `AR_FP_CONTROL, 64'h1800, 64'h1800, 0}};
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("flags reset", legacy_flags_o, 64'h2);
        foreach (rows[i])
        begin
            ar_op(1, rows[i].lg, rows[i].idx, rows[i].wd);
            chk("fault", rsv_field_fault_o, rows[i].f);
            ar_op(0, 0, rows[i].idx, 0);
            chk("ar read", ar_rdata_o, rows[i].rd);
        end
        upd(0);
        chk("legacy update", legacy_flags_o, 64'h3F_7FD7);
        upd(1);
        chk("write wins", legacy_flags_o, 64'h2);
        // stack top is 3 now, so logical 2 lands on physical 13
        fp_op(1, 0, 7'd13, 0, 80'h1_2345);
        fp_op(1, 0, 7'd8, 0, 80'h6_789A);
        fp_op(0, 1, 7'd10, 0, 0);
        chk("legacy map", fp_rdata_o, 80'h1_2345);
        fp_op(0, 0, 7'd8, 0, 0);
        chk("native map", fp_rdata_o, 80'h6_789A);
        for (int k = 1; k < 3; k++)
        begin
            logic [14:0] exp_mark;
            exp_mark = (k == 1) ? `EXP_SGL_DENORM : `EXP_DBL_DENORM;
            fp_op(1, 0, 7'd9, k[1:0], 80'h40_0000);
            fp_op(0, 0, 7'd9, 0, 0);
            chk("marked exp", fp_rdata_o[78:64], exp_mark);
            chk("kept sig", fp_rdata_o[63:0], 64'h40_0000);
            fp_op(0, 1, 7'd14, 0, 0);
            chk("invalid fault", fp_invalid_fault_o, 1);
            // legacy code takes the value in through its own load, not a native register
            fp_op(1, 1, 7'd8, k[1:0], 80'h40_0000);
            fp_op(0, 1, 7'd8, 0, 0);
            chk("normalized", fp_rdata_o[63], 1);
            chk("no fault", fp_invalid_fault_o, 0);
        end
        // mid-run reset: registers go back to their reset values
        @(posedge clk_i);
        rst_b_i <= 0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("flags in reset", legacy_flags_o, `FLG_RESET);
        chk("fault in reset", rsv_field_fault_o, 0);
        @(posedge clk_i);
        rst_b_i <= 1;
        repeat (3) @(posedge clk_i);
        ar_op(0, 0, `AR_FP_CONTROL, 0);
        chk("control after reset", ar_rdata_o, 0);
        ar_op(0, 0, `AR_FLAGS, 0);
        chk("flags after reset", ar_rdata_o, `FLG_RESET);
        summarize();
    end
endmodule
